/* core/rxld_core.sv */
`timescale 1ns/10ps
`default_nettype none

module rxld_core #(
	parameter int unsigned WINDOW = rxld_pkg::WINDOW_EDGES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic rx_serial_in,
	input wire logic rx_bit_order_select,
	input wire rxld_pkg::rxld_ref_t refs,
	input wire logic lock_to_ref_n,
	input wire logic [7:0] rx_amplitude,
	input wire logic [7:0] absence_threshold_in,
	input wire logic absence_detect_off,
	output logic [rxld_pkg::WORD_W-1:0] rx_parallel_out,
	output logic rx_word_clock_primary,
	output logic rx_word_clock_secondary,
	output logic rx_lock_lost_n,
	output logic signal_absent_n,
	output logic cdr_reacquire,
	output logic cdr_track_ref
);
	import rxld_pkg::*;

	// ----------------------------------------
	// Thresholds in counts per window
	// ----------------------------------------
	localparam logic [CNT_W-1:0] OOL_CNT = rxld_ppm_count(WINDOW, OOL_PPM);
	localparam logic [CNT_W-1:0] LOCK_CNT = rxld_ppm_count(WINDOW, LOCK_PPM);
	localparam logic [CNT_W-1:0] WANDER_CNT = rxld_ppm_count(WINDOW, WANDER_PPM);

	// ----------------------------------------
	// Reference selection and validity
	// ----------------------------------------
	logic ref_prev;
	logic [7:0] ref_quiet;
	logic ref_valid;
	wire logic ref_level = refs.ref_source_select ? refs.reference_clock_in :
		refs.tx_word_clock_in;
	wire logic ref_rise = ref_level && !ref_prev;
	wire logic ref_timeout = (ref_quiet == 8'(REF_LOSS_CYC - 1));
	wire logic next_ref_valid = ref_rise || (ref_valid && !ref_timeout);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_prev <= 1'b0;
			ref_quiet <= REF_LOSS_RST;
			ref_valid <= 1'b0;
		end else if (ce) begin
			ref_prev <= ref_level;
			ref_quiet <= (ref_rise || ref_timeout) ? REF_LOSS_RST : ref_quiet + 8'h01;
			ref_valid <= next_ref_valid;
		end
	end

	// ----------------------------------------
	// Deserializer
	// ----------------------------------------
	logic [1:0] bit_cnt;
	logic [WORD_W-1:0] asm_word;
	logic [1:0] sec_div;
	wire logic ltr_active = !lock_to_ref_n;
	wire logic word_wrap = (bit_cnt == BIT_LAST);
	wire logic [1:0] bit_pos = rx_bit_order_select ? (BIT_LAST - bit_cnt) : bit_cnt;
	wire logic [WORD_W-1:0] bit_mask = WORD_W'(1) << bit_pos;
	wire logic [WORD_W-1:0] next_asm = rx_serial_in ? (asm_word | bit_mask) :
		(asm_word & ~bit_mask);
	wire logic [1:0] next_bit_cnt = bit_cnt + 2'h1;
	// Word tick is the divided recovered clock; in reference mode it follows the reference
	wire logic word_tick = ltr_active ? ref_rise : word_wrap;
	// High over the first two bits of a word; the first word after reset gets no edge
	wire logic next_primary = ltr_active ? ref_level :
		(word_wrap || ((next_bit_cnt == BIT_SECOND) && rx_word_clock_primary));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt <= BIT_FIRST;
			asm_word <= WORD_RST;
			rx_parallel_out <= WORD_RST;
		end else if (ce) begin
			bit_cnt <= next_bit_cnt;
			asm_word <= word_wrap ? WORD_RST : next_asm;
			if (word_wrap) begin
				rx_parallel_out <= next_asm;
			end
		end
	end

	// Secondary clock is a quarter of the primary word clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_div <= 2'h0;
			rx_word_clock_primary <= 1'b0;
			rx_word_clock_secondary <= 1'b0;
		end else if (ce) begin
			sec_div <= sec_div + 2'(word_tick);
			rx_word_clock_primary <= next_primary;
			rx_word_clock_secondary <= sec_div[1];
		end
	end

	// ----------------------------------------
	// Frequency measurement
	// ----------------------------------------
	rxld_meas_t meas;

	rxld_freq_meter #(
		.WINDOW(WINDOW)
	) u_meter (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.restart(!ref_valid),
		.ref_tick(ref_rise),
		.word_tick(word_tick),
		.meas(meas)
	);

	// ----------------------------------------
	// Lock state
	// ----------------------------------------
	rxld_lock_t state;
	rxld_lock_t next_state;
	wire logic meas_ool = meas.done && (meas.diff > OOL_CNT);
	wire logic meas_in = meas.done && (meas.diff <= LOCK_CNT);
	// Beyond the wander band the loop is far off; it still reads as plain out-of-lock
	wire logic meas_wild = meas.done && (meas.diff > WANDER_CNT);

	always_comb begin
		next_state = state;
		if (!ref_valid) begin
			next_state = RXLD_NO_REF;
		end else begin
			unique case (state)
				RXLD_NO_REF: begin
					next_state = RXLD_ACQUIRE;
				end
				RXLD_ACQUIRE: begin
					if (meas_in) begin
						next_state = RXLD_LOCKED;
					end
				end
				RXLD_LOCKED: begin
					if (meas_ool || meas_wild) begin
						next_state = RXLD_ACQUIRE;
					end
				end
				default: begin
					next_state = RXLD_NO_REF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Signal absence with hysteresis
	// ----------------------------------------
	logic los_active;
	wire logic [8:0] clear_level = {1'b0, absence_threshold_in} + {1'b0, LOS_HYST};
	wire logic amp_low = rx_amplitude < absence_threshold_in;
	wire logic amp_clear = {1'b0, rx_amplitude} >= clear_level;
	wire logic next_los = absence_detect_off ? 1'b0 :
		(los_active ? !amp_clear : amp_low);
	// Absence only forces the flag when reference mode is off
	wire logic next_lol = (next_state != RXLD_LOCKED) ||
		(next_los && lock_to_ref_n);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= RXLD_NO_REF;
			los_active <= 1'b0;
			rx_lock_lost_n <= 1'b0;
			signal_absent_n <= 1'b1;
			cdr_reacquire <= 1'b0;
			cdr_track_ref <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			los_active <= next_los;
			rx_lock_lost_n <= !next_lol;
			signal_absent_n <= !next_los;
			cdr_reacquire <= (next_state != RXLD_LOCKED) && lock_to_ref_n;
			cdr_track_ref <= ltr_active;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_order_ascending: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && word_wrap && !rx_bit_order_select) |=> rx_parallel_out[3] == $past(rx_serial_in))
		else $error("last bit not on bit 3 in ascending order");

	a_order_descending: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && word_wrap && rx_bit_order_select) |=> rx_parallel_out[0] == $past(rx_serial_in))
		else $error("last bit not on bit 0 in descending order");

	a_word_clock_align: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && $past(ce) && word_wrap && lock_to_ref_n && $past(lock_to_ref_n))
		|=> $rose(rx_word_clock_primary))
		else $error("word clock did not rise with new word");

	a_lol_no_ref: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && !ref_valid) |=> !rx_lock_lost_n ##0 state == RXLD_NO_REF)
		else $error("lock flag clear without reference");

	a_lol_on_absence: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && next_los && lock_to_ref_n) |=> !rx_lock_lost_n && !signal_absent_n)
		else $error("absence did not force lock flag");

	a_ool_unlock: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && state == RXLD_LOCKED && meas_ool) |=> state != RXLD_LOCKED && !rx_lock_lost_n)
		else $error("out-of-lock window did not unlock");

	a_lol_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && state != RXLD_LOCKED && !meas_in) |=> state != RXLD_LOCKED)
		else $error("locked without a lock-in window");

	a_absence_off: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && absence_detect_off) |=> signal_absent_n && !los_active)
		else $error("absence output active while detection off");

	a_ref_mode_track: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && !lock_to_ref_n) |=> cdr_track_ref && !cdr_reacquire)
		else $error("reference mode not followed");

	a_absence_hyst: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && los_active && !absence_detect_off && !amp_clear) |=> los_active)
		else $error("absence cleared inside hysteresis band");

	a_ltr_clock_follows: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && !lock_to_ref_n) |=> rx_word_clock_primary == $past(ref_level))
		else $error("primary clock not following reference");

endmodule

`default_nettype wire

/* shared/rxld_pkg.sv */
package rxld_pkg;

	// ----------------------------------------
	// Word assembly
	// ----------------------------------------
	localparam int unsigned WORD_W = 4;
	localparam logic [1:0] BIT_LAST = 2'h3;
	localparam logic [1:0] BIT_FIRST = 2'h0;
	localparam logic [1:0] BIT_SECOND = 2'h1;

	// ----------------------------------------
	// Timing and thresholds
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned PPM_SCALE = 1_000_000;
	localparam int unsigned OOL_PPM = 732;
	localparam int unsigned LOCK_PPM = 240;
	localparam int unsigned WANDER_PPM = 1000;
	localparam int unsigned WINDOW_EDGES = 8192;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned REF_LOSS_NS = 3200;
	// Longest quiet gap on the reference, rounded down to whole cycles
	localparam int unsigned REF_LOSS_CYC = (REF_LOSS_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam logic [7:0] LOS_HYST = 8'h08;
	localparam logic [7:0] REF_LOSS_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_RST = 4'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		RXLD_NO_REF,
		RXLD_ACQUIRE,
		RXLD_LOCKED
	} rxld_lock_t;

	typedef struct packed {
		logic reference_clock_in;
		logic tx_word_clock_in;
		logic ref_source_select;
	} rxld_ref_t;

	typedef struct packed {
		logic done;
		logic [CNT_W-1:0] diff;
	} rxld_meas_t;

	// Deviation in counts over the window for a given ppm figure
	function automatic logic [CNT_W-1:0] rxld_ppm_count(input int unsigned win,
		input int unsigned ppm);
		return CNT_W'((win * ppm) / PPM_SCALE);
	endfunction

endpackage

/* core/rxld_freq_meter.sv */
`timescale 1ns/10ps
`default_nettype none

module rxld_freq_meter #(
	parameter int unsigned WINDOW = rxld_pkg::WINDOW_EDGES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic restart,
	input wire logic ref_tick,
	input wire logic word_tick,
	output rxld_pkg::rxld_meas_t meas
);
	import rxld_pkg::*;

	// ----------------------------------------
	// Window counters
	// ----------------------------------------
	logic [CNT_W-1:0] ref_cnt;
	logic [CNT_W-1:0] word_cnt;
	wire logic win_end = ref_tick && (ref_cnt == CNT_W'(WINDOW - 1));
	wire logic [CNT_W-1:0] word_total = word_cnt + CNT_W'(word_tick);
	wire logic word_sat = (word_cnt == {CNT_W{1'b1}});
	wire logic [CNT_W-1:0] expected = CNT_W'(WINDOW);
	// Magnitude of the count error; both sides are unsigned
	wire logic [CNT_W-1:0] next_diff = (word_total >= expected) ?
		(word_total - expected) : (expected - word_total);

	// Window is timed by the reference, the recovered side is counted in it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_cnt <= CNT_RST;
			word_cnt <= CNT_RST;
			meas <= '0;
		end else if (ce) begin
			meas.done <= win_end && !restart;
			if (restart || win_end) begin
				ref_cnt <= CNT_RST;
				word_cnt <= CNT_RST;
				meas.diff <= restart ? meas.diff : next_diff;
			end else begin
				ref_cnt <= ref_cnt + CNT_W'(ref_tick);
				word_cnt <= word_sat ? word_cnt : word_total;
			end
		end
	end

endmodule

`default_nettype wire

/* tb/rxld_framer_model.sv */
`timescale 1ns/10ps
`default_nettype none

module rxld_framer_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [rxld_pkg::WORD_W-1:0] word,
	input wire logic word_clk
);
	import rxld_pkg::*;

	// ----------------------------------------
	// Word capture
	// ----------------------------------------
	logic wclk_q;
	logic [WORD_W-1:0] got[$];

	// Taken one edge after the word clock rises, while the word still stands
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wclk_q <= 1'b0;
		end else begin
			wclk_q <= word_clk;
			if (word_clk && !wclk_q) begin
				got.push_back(word);
			end
		end
	end
endmodule

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import rxld_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int unsigned WIN = 256;
	localparam int LIMIT = 40000;
	logic clk, rst_b, ser, order_sel, ltr_n, ltr_val, ltr_tie, det_off, ref_on, tx_on;
	rxld_ref_t refs;
	logic [7:0] amp, thr;
	logic [WORD_W-1:0] word;
	logic wclk1, wclk2, lost_n, absent_n, reacq, track, ce, ref_sel, w1q, w2q;
	int err_count = 0, samples_checked = 0, cyc = 0, bitk = 0, rc = 0, rper = 4;
	int r1 = 0, r2 = 0, s1, s2;

	rxld_core #(.WINDOW(WIN)) i_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
		.rx_serial_in(ser), .rx_bit_order_select(order_sel), .refs(refs),
		.lock_to_ref_n(ltr_n), .rx_amplitude(amp), .absence_threshold_in(thr),
		.absence_detect_off(det_off), .rx_parallel_out(word),
		.rx_word_clock_primary(wclk1), .rx_word_clock_secondary(wclk2),
		.rx_lock_lost_n(lost_n), .signal_absent_n(absent_n),
		.cdr_reacquire(reacq), .cdr_track_ref(track));

	rxld_framer_model i_framer (.clk(clk), .rst_b(rst_b), .word(word), .word_clk(wclk1));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------
	// Stimulus streams
	// ----------------------------------------
	// Word n of the stream carries the count n, first bit in time = bit 0
	function automatic logic sbit(input int k);
		logic [31:0] w;
		w = k >> 2;
		return w[k % 4];
	endfunction

	function automatic logic [3:0] dec(input logic [3:0] w, input logic sel);
		return sel ? {w[0], w[1], w[2], w[3]} : w;
	endfunction

	always @(posedge clk) begin
		cyc <= cyc + 1;
		// The stream pauses with the enable so no bit is lost
		if (!rst_b || ce) begin
			bitk <= rst_b ? bitk + 1 : 1;
			ser <= sbit(rst_b ? bitk : 0);
		end
		rc <= (rc + 1 >= rper) ? 0 : rc + 1;
		refs.reference_clock_in <= ref_on & (rc < 2);
		refs.tx_word_clock_in <= tx_on & (rc < 2);
		refs.ref_source_select <= ref_sel;
		ltr_n <= ltr_tie ? absent_n : ltr_val;
		w1q <= wclk1;
		w2q <= wclk2;
		r1 <= r1 + int'(wclk1 && !w1q);
		r2 <= r2 + int'(wclk2 && !w2q);
		if (cyc == LIMIT) begin
			err_count++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Checking tasks
	// ----------------------------------------
	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	// Successive words must count up once decoded with the chosen order
	task automatic check_words(input logic sel);
		check(4'(i_framer.got.size() >= 15), 4'h1);
		for (int i = 1; i < i_framer.got.size(); i++) begin
			check(dec(i_framer.got[i], sel), dec(i_framer.got[i-1], sel) + 4'h1);
		end
		i_framer.got.delete();
	endtask

	// Bounded wait, since the lock decision lands only at a window end or at the reference timeout
	task automatic wait_lost(input logic v, input int n);
		for (int i = 0; i < n && lost_n !== v; i++) @(negedge clk);
		check({3'h0, lost_n}, {3'h0, v});
	endtask

	task automatic end_of_test();
		$display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		order_sel = 1'b0;
		ltr_val = 1'b1;
		ltr_tie = 1'b0;
		det_off = 1'b0;
		ref_on = 1'b1;
		tx_on = 1'b0;
		ref_sel = 1'b1;
		amp = 8'h64;
		thr = 8'h32;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		step(80);
		check(i_framer.got[0], 4'h0);
		check_words(1'b0);
		s1 = r1;
		s2 = r2;
		step(64);
		check({3'h0, r1 - s1 == 16}, 4'h1);
		check({3'h0, r2 - s2 == 4}, 4'h1);
		@(posedge clk) order_sel <= 1'b1;
		step(8);
		i_framer.got.delete();
		step(40);
		// A frozen stretch must neither drop nor repeat a word
		@(posedge clk) ce <= 1'b0;
		step(5);
		@(posedge clk) ce <= 1'b1;
		step(40);
		check_words(1'b1);
		wait_lost(1'b1, 4000);
		@(posedge clk) rper <= 5;
		wait_lost(1'b0, 4000);
		check({3'h0, reacq}, 4'h1);
		@(posedge clk) rper <= 4;
		wait_lost(1'b1, 4000);
		@(posedge clk) ref_sel <= 1'b0;
		tx_on <= 1'b1;
		ref_on <= 1'b0;
		wait_lost(1'b1, 4000);
		@(posedge clk) tx_on <= 1'b0;
		wait_lost(1'b0, 70);
		@(posedge clk) tx_on <= 1'b1;
		wait_lost(1'b1, 4000);
		@(posedge clk) amp <= 8'h28;
		step(2);
		check({3'h0, absent_n}, 4'h0);
		check({3'h0, lost_n}, 4'h0);
		@(posedge clk) amp <= 8'h39;
		step(3);
		check({3'h0, absent_n}, 4'h0);
		@(posedge clk) amp <= 8'h3a;
		step(2);
		check({3'h0, absent_n}, 4'h1);
		wait_lost(1'b1, 4000);
		@(posedge clk) det_off <= 1'b1;
		amp <= 8'h28;
		step(3);
		check({3'h0, absent_n}, 4'h1);
		check({3'h0, lost_n}, 4'h1);
		@(posedge clk) det_off <= 1'b0;
		ltr_tie <= 1'b1;
		step(4);
		check({3'h0, track}, 4'h1);
		wait_lost(1'b1, 4000);
		end_of_test();
	end
endmodule

`default_nettype wire
